// [mps_core_model.sv]
// Behavioural motion core that answers the sequencer's issued moves, one counter per axis.
// Assumes dly is at least one; done stays high four cycles so the two-flop sync sees it.
`timescale 1ns/1ps
`default_nettype none
module mps_core_model (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Move requests and answer delay
	input  wire logic [3:0]  mv_start,
	input  wire logic [15:0] dly,
	// Status back to the sequencer
	output logic      [3:0]  moving,
	output logic      [3:0]  mv_done
);
	logic [15:0] cnt [4];

	// Done drops as the counter reaches zero, and a new start clears it, so a following move always sees a fresh edge.
	always @(posedge pclk or negedge presetn) begin
		for (int i = 0; i < 4; i++) begin
			if (!presetn) begin
				cnt[i] <= 16'h0000;
				moving[i] <= 1'b0;
				mv_done[i] <= 1'b0;
			end else if (mv_start[i]) begin
				cnt[i] <= dly + 16'h0005;
				moving[i] <= 1'b1;
				mv_done[i] <= 1'b0;
			end else if (cnt[i] != 16'h0000) begin
				cnt[i] <= cnt[i] - 16'h0001;
				if (cnt[i] == 16'h0005) begin
					moving[i] <= 1'b0;
					mv_done[i] <= 1'b1;
				end
				if (cnt[i] == 16'h0001) begin
					mv_done[i] <= 1'b0;
				end
			end
		end
	end
endmodule : mps_core_model
`default_nettype wire

// [mps_mem.sv]
// Program memory for statements and entry tables: one write port, one registered read port.
// Assumes both ports run on pclk.
`timescale 1ns/1ps
`default_nettype none
module mps_mem (
	// Clock
	input  wire logic        clk,
	// Write port
	input  wire logic        we,
	input  wire logic [10:0] waddr,
	input  wire logic [31:0] wdata,
	// Read port
	input  wire logic [10:0] raddr,
	output var  logic [31:0] rdata
);
	logic [31:0] mem [0:2047];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : mps_mem
`default_nettype wire

// [mps_pkg.sv]
// Shared constants for the motion program sequencer: register map, statement encoding, states and timing.
// Assumes a 100 MHz pclk and a 32-bit APB register bus.
package mps_pkg;

	localparam int NAX   = 4;
	localparam int NPROG = 10;
	localparam int NSUB  = 40;
	localparam int NEST  = 8;
	localparam int NPAR  = 8;

	// Register byte offsets.
	localparam logic [11:0] A_CTRL  = 12'h000;
	localparam logic [11:0] A_PSEL  = 12'h004;
	localparam logic [11:0] A_LDADR = 12'h008;
	localparam logic [11:0] A_LDDAT = 12'h00C;
	localparam logic [11:0] A_STAT  = 12'h010;
	localparam logic [11:0] A_BLK01 = 12'h014;
	localparam logic [11:0] A_BLK23 = 12'h018;
	localparam logic [11:0] A_PAR0  = 12'h040;

	// Field positions inside the control and status registers.
	localparam int F_RUN    = 0;
	localparam int F_ABORT  = 4;
	localparam int F_ENDRV  = 8;
	localparam int F_ACT    = 0;
	localparam int F_REFUSE = 4;
	localparam int F_ERR    = 8;

	// Reset values.
	localparam logic [3:0]  RST_ABORT = 4'hF;
	localparam logic [3:0]  RST_ENDRV = 4'h0;
	localparam logic [15:0] RST_PSEL  = 16'h0000;

	// Statement word fields.
	localparam int I_OP  = 28;
	localparam int I_AX  = 26;
	localparam int I_FLG = 25;
	localparam int I_IDX = 20;

	// Entry tables for programs and subroutines in program memory.
	localparam logic [10:0] TBL_PROG = 11'h400;
	localparam logic [10:0] TBL_SUB  = 11'h410;
	localparam int          E_VALID  = 31;
	localparam int          E_MULTI  = 30;

	// Synchronised pin vector layout.
	localparam int PIN_DRV  = 0;
	localparam int PIN_POS  = 4;
	localparam int PIN_MOV  = 8;
	localparam int PIN_OT   = 12;
	localparam int PIN_LIM  = 16;
	localparam int PIN_EOT  = 20;
	localparam int PIN_SERR = 24;
	localparam int PIN_DONE = 28;
	localparam int PIN_CTL  = 32;
	localparam int PIN_W    = 64;

	// Timing.
	localparam int CLK_MHZ   = 100;
	localparam int T_GAP_US  = 2000;
	localparam int T_GAP_CYC = T_GAP_US * CLK_MHZ;

	typedef enum logic [3:0] {
		OP_NOP   = 4'h0,
		OP_CALL  = 4'h1,
		OP_JUMP  = 4'h2,
		OP_LABEL = 4'h3,
		OP_SYNC  = 4'h4,
		OP_LOAD  = 4'h5,
		OP_SET_ACCELERATION = 4'h6,
		OP_SET_VELOCITY = 4'h7,
		OP_POSITIONING_MOVE = 4'h8,
		OP_CONTINUOUS_MOVE = 4'h9,
		OP_DWELL = 4'hA,
		OP_WAIT  = 4'hB,
		OP_PEND  = 4'hC,
		OP_SEND  = 4'hD
	} mps_op_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ENTRY = 3'b001,
		ST_FETCH = 3'b010,
		ST_CALLT = 3'b011,
		ST_SYNCW = 3'b100
	} mps_st_t;

endpackage : mps_pkg

// [mps_seq.sv]
// Motion program sequencer for four axes, with an APB register slave and a loadable program store.
// Assumes status pins arrive asynchronously and a motion core outside runs the issued moves.
//
// What this block does
// - Runs selected program block by block autonomously.
// - Stores ten programs and forty subroutines.
// - Four axes start independently or together.
// - One program per axis at a time.
// - Subroutine nesting limited to eight levels.
// - Calls must match single or multi type.
// - Synchronisation allowed only in multi-axis code.
// - Multi-axis code addresses axes one, two only.
// - Multi-axis start needs both axes ready.
// - Consecutive moves follow within two milliseconds.
// - Synchronised two-axis move starts within two milliseconds.
// - Jumps redirect; conditional ones test control bit.
// - Call runs subroutine then resumes after it.
// - Unlabelled block keeps the previous label.
// - Current block label reported per axis.
// - Settings persist; load writes parameter register.
// - Block ends at its one motion statement.
// - Settings, conditional jumps act at next motion.
// - Next block prepared while current one runs.
// - Each axis executes only its own statements.
// - First axis at sync waits for other.
// - Start only when all prerequisites hold.
// - Stop at once on abort or faults.
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module mps_seq
	import mps_pkg::*;
#(
	parameter int GAP_LIMIT_CYC = mps_pkg::T_GAP_CYC
) (
	// Clock and reset
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	// APB slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output var  logic [31:0]               prdata,
	output var  logic                      pready,
	output var  logic                      pslverr,
	// Axis status pins, one bit per axis, and the 32 external control bits
	input  wire logic [mps_pkg::NAX-1:0]   drive_ok,
	input  wire logic [mps_pkg::NAX-1:0]   pos_valid,
	input  wire logic [mps_pkg::NAX-1:0]   moving,
	input  wire logic [mps_pkg::NAX-1:0]   ot_ok,
	input  wire logic [mps_pkg::NAX-1:0]   in_limits,
	input  wire logic [mps_pkg::NAX-1:0]   eot_hit,
	input  wire logic [mps_pkg::NAX-1:0]   stop_err,
	input  wire logic [mps_pkg::NAX-1:0]   mv_done,
	input  wire logic [31:0]               external_control_bit,
	// Move commands to the motion core
	output var  logic [mps_pkg::NAX-1:0]   mv_start,
	output var  logic [2*mps_pkg::NAX-1:0] mv_kind,
	output var  logic [32*mps_pkg::NAX-1:0] mv_value,
	output var  logic [16*mps_pkg::NAX-1:0] mv_vel,
	output var  logic [16*mps_pkg::NAX-1:0] mv_acc
);
	import mps_pkg::*;

	typedef struct packed {
		mps_st_t                st;
		logic [9:0]             pc;
		logic [3:0]             sp;
		logic [NEST-1:0][9:0]   stk;
		logic [10:0]            tgt;
		logic                   multi;
		logic                   busy;
		logic [1:0]             sync_c;
		logic [15:0]            lbl;
		logic [15:0]            lblp;
		logic [15:0]            vel;
		logic [15:0]            velp;
		logic [15:0]            acc;
		logic [15:0]            accp;
		logic                   mv_start;
		logic [1:0]             mv_kind;
		logic [31:0]            mv_val;
	} mps_ax_t;

	typedef struct packed {
		mps_ax_t [NAX-1:0]      ax;
		logic [1:0]             slot;
		logic [1:0]             dslot;
		logic                   dv;
		logic [PIN_W-1:0]       s1;
		logic [PIN_W-1:0]       s2;
		logic [NAX-1:0]         dd;
		logic [NAX-1:0]         abort;
		logic [NAX-1:0]         endrv;
		logic [15:0]            psel;
		logic [10:0]            ldadr;
		logic [NPAR-1:0][31:0]  par;
		logic [NAX-1:0]         refuse;
		logic [NAX-1:0]         err;
		logic                   mwe;
		logic [10:0]            mwa;
		logic [31:0]            mwd;
		logic                   pready;
		logic                   pslverr;
		logic [31:0]            prdata;
		logic [17:0]            gap;
	} mps_state_t;

	mps_state_t  r;
	mps_state_t  n;
	logic [31:0] rdata;
	logic [10:0] raddr;
	logic [NAX-1:0] pre_ok;

	function automatic logic mps_ready(input logic en, ab, drv, pos, mov, ot, lim);
		return en & !ab & drv & pos & !mov & ot & lim;
	endfunction : mps_ready

	// Statements and entry tables share one store, so calls and starts cost one table read.
	assign raddr = (r.ax[r.slot].st == ST_ENTRY || r.ax[r.slot].st == ST_CALLT) ?
		r.ax[r.slot].tgt : {1'b0, r.ax[r.slot].pc};

	mps_mem u_mem (
		.clk   (pclk),
		.we    (r.mwe),
		.waddr (r.mwa),
		.wdata (r.mwd),
		.raddr (raddr),
		.rdata (rdata)
	);

	assign prdata  = r.prdata;
	assign pready  = r.pready;
	assign pslverr = r.pslverr;

	for (genvar i = 0; i < NAX; i++) begin : g_ax
		assign pre_ok[i] = mps_ready(r.endrv[i], r.abort[i], r.s2[PIN_DRV+i], r.s2[PIN_POS+i],
			r.s2[PIN_MOV+i], r.s2[PIN_OT+i], r.s2[PIN_LIM+i]);
		assign mv_start[i]          = r.ax[i].mv_start;
		assign mv_kind[2*i +: 2]    = r.ax[i].mv_kind;
		assign mv_value[32*i +: 32] = r.ax[i].mv_val;
		assign mv_vel[16*i +: 16]   = r.ax[i].vel;
		assign mv_acc[16*i +: 16]   = r.ax[i].acc;
	end

	always_comb begin
		logic [1:0]     a;
		logic [31:0]    w;
		mps_op_t        op;
		logic           mine;
		logic           acc;
		logic [3:0]     pn;
		logic [NAX-1:0] kill;
		logic [NAX-1:0] stp;
		a    = r.dslot;
		w    = rdata;
		op   = mps_op_t'(rdata[I_OP +: 4]);
		mine = !r.ax[r.dslot].multi || (rdata[I_AX +: 2] == r.dslot);
		acc  = psel & penable & r.pready;
		pn   = 4'h0;
		kill = '0;
		stp  = '0;
		n    = r;
		n.s1 = {external_control_bit, mv_done, stop_err, eot_hit, in_limits, ot_ok, moving, pos_valid, drive_ok};
		n.s2 = r.s1;
		n.dd = r.s2[PIN_DONE +: NAX];
		n.slot  = r.slot + 2'd1;
		n.dslot = r.slot;
		n.dv    = r.ax[r.slot].st != ST_IDLE && r.ax[r.slot].st != ST_SYNCW;
		n.mwe   = 1'b0;
		n.pready  = psel & penable & !r.pready;
		n.pslverr = 1'b0;
		n.prdata  = 32'h0000_0000;
		for (int i = 0; i < NAX; i++) begin
			n.ax[i].mv_start = 1'b0;
			if (r.s2[PIN_DONE+i] && !r.dd[i]) begin
				n.ax[i].busy = 1'b0;
			end
		end
		// Answer is prepared one cycle ahead so it is held when pready rises.
		if (psel && penable && !r.pready) begin
			case (paddr)
				A_CTRL:  n.prdata = {20'h0, r.endrv, r.abort, 4'h0};
				A_PSEL:  n.prdata = {16'h0, r.psel};
				A_LDADR: n.prdata = {21'h0, r.ldadr};
				A_LDDAT: n.prdata = 32'h0000_0000;
				A_STAT: begin
					for (int i = 0; i < NAX; i++) begin
						n.prdata[F_ACT+i] = r.ax[i].st != ST_IDLE;
					end
					n.prdata[F_REFUSE +: NAX] = r.refuse;
					n.prdata[F_ERR +: NAX]    = r.err;
				end
				A_BLK01: n.prdata = {r.ax[1].lbl, r.ax[0].lbl};
				A_BLK23: n.prdata = {r.ax[3].lbl, r.ax[2].lbl};
				default: begin
					if (paddr[11:5] == A_PAR0[11:5]) begin
						n.prdata = r.par[paddr[4:2]];
					end else begin
						n.pslverr = 1'b1;
					end
				end
			endcase
		end
		if (acc && pwrite) begin
			case (paddr)
				A_CTRL: begin
					n.abort = pwdata[F_ABORT +: NAX];
					n.endrv = pwdata[F_ENDRV +: NAX];
					for (int i = 0; i < NAX; i++) begin
						pn = r.psel[4*i +: 4];
						if (pwdata[F_RUN+i]) begin
							if (r.ax[i].st == ST_IDLE && pre_ok[i] && pn != 4'h0 && pn <= NPROG) begin
								n.ax[i].st     = ST_ENTRY;
								n.ax[i].tgt    = TBL_PROG + {7'h00, pn} - 11'h001;
								n.ax[i].sp     = 4'h0;
								n.ax[i].multi  = 1'b0;
								n.ax[i].busy   = 1'b0;
								n.ax[i].sync_c = 2'h0;
							end else begin
								n.refuse[i] = 1'b1;
							end
						end
					end
				end
				A_PSEL:  n.psel = pwdata[15:0];
				A_LDADR: n.ldadr = pwdata[10:0];
				A_LDDAT: begin
					n.mwe   = 1'b1;
					n.mwa   = r.ldadr;
					n.mwd   = pwdata;
					n.ldadr = r.ldadr + 11'h001;
				end
				A_STAT: begin
					n.refuse = n.refuse & ~pwdata[F_REFUSE +: NAX];
					n.err    = r.err & ~pwdata[F_ERR +: NAX];
				end
				default: begin
					if (paddr[11:5] == A_PAR0[11:5]) begin
						n.par[paddr[4:2]] = pwdata;
					end
				end
			endcase
		end
		// One statement per cycle, axes served in turn; decode may run ahead of the move in progress.
		if (r.dv) begin
			case (r.ax[a].st)
				ST_ENTRY: begin
					if (!w[E_VALID]) begin
						kill[a]     = 1'b1;
						n.refuse[a] = 1'b1;
					end else if (w[E_MULTI]) begin
						if (a != 2'd0 || r.ax[1].st != ST_IDLE || !pre_ok[1]) begin
							kill[a]     = 1'b1;
							n.refuse[a] = 1'b1;
						end else begin
							n.ax[1]       = r.ax[0];
							n.ax[1].lbl   = r.ax[1].lbl;
							n.ax[1].vel   = r.ax[1].vel;
							n.ax[1].acc   = r.ax[1].acc;
							n.ax[1].st    = ST_FETCH;
							n.ax[1].pc    = w[9:0];
							n.ax[1].multi = 1'b1;
							n.ax[0].st    = ST_FETCH;
							n.ax[0].pc    = w[9:0];
							n.ax[0].multi = 1'b1;
						end
					end else begin
						n.ax[a].st = ST_FETCH;
						n.ax[a].pc = w[9:0];
					end
				end
				ST_CALLT: begin
					if (!w[E_VALID] || w[E_MULTI] != r.ax[a].multi) begin
						kill[a] = 1'b1;
					end else begin
						n.ax[a].stk[r.ax[a].sp[2:0]] = r.ax[a].pc + 10'h001;
						n.ax[a].sp = r.ax[a].sp + 4'h1;
						n.ax[a].pc = w[9:0];
						n.ax[a].st = ST_FETCH;
					end
				end
				ST_FETCH: begin
					if (r.ax[a].multi && w[I_AX +: 2] > 2'd1) begin
						kill[a] = 1'b1;
					end else begin
						case (op)
							OP_NOP:   n.ax[a].pc = r.ax[a].pc + 10'h001;
							OP_LABEL: begin
								n.ax[a].lblp = w[15:0];
								n.ax[a].pc   = r.ax[a].pc + 10'h001;
							end
							OP_JUMP: begin
								if (!w[I_FLG]) begin
									n.ax[a].pc = w[9:0];
								end else if (!r.ax[a].busy) begin
									n.ax[a].pc = r.s2[PIN_CTL + w[I_IDX +: 5]] ? w[9:0] : r.ax[a].pc + 10'h001;
								end
							end
							OP_CALL: begin
								if (r.ax[a].sp == NEST || w[15:0] == 16'h0000 || w[15:0] > NSUB) begin
									kill[a] = 1'b1;
								end else begin
									n.ax[a].tgt = TBL_SUB + {5'h00, w[5:0]} - 11'h001;
									n.ax[a].st  = ST_CALLT;
								end
							end
							OP_SYNC: begin
								if (!r.ax[a].multi) begin
									kill[a] = 1'b1;
								end else if (!r.ax[a].busy) begin
									n.ax[a].sync_c = r.ax[a].sync_c + 2'd1;
									n.ax[a].st     = ST_SYNCW;
									n.ax[a].pc     = r.ax[a].pc + 10'h001;
								end
							end
							OP_LOAD: begin
								if (mine) begin
									n.par[w[I_IDX +: 3]] = {{16{w[15]}}, w[15:0]};
								end
								n.ax[a].pc = r.ax[a].pc + 10'h001;
							end
							OP_SET_ACCELERATION, OP_SET_VELOCITY: begin
								if (mine && op == OP_SET_ACCELERATION) begin
									n.ax[a].accp = w[15:0];
								end
								if (mine && op == OP_SET_VELOCITY) begin
									n.ax[a].velp = w[15:0];
								end
								n.ax[a].pc = r.ax[a].pc + 10'h001;
							end
							OP_POSITIONING_MOVE, OP_CONTINUOUS_MOVE, OP_DWELL, OP_WAIT: begin
								if (!mine) begin
									n.ax[a].pc = r.ax[a].pc + 10'h001;
								end else if (!r.ax[a].busy) begin
									n.ax[a].mv_start = 1'b1;
									n.ax[a].mv_kind  = op[1:0];
									n.ax[a].mv_val   = w[I_FLG] ? r.par[w[I_IDX +: 3]] : {{16{w[15]}}, w[15:0]};
									n.ax[a].vel      = r.ax[a].velp;
									n.ax[a].acc      = r.ax[a].accp;
									n.ax[a].lbl      = r.ax[a].lblp;
									n.ax[a].busy     = 1'b1;
									n.ax[a].pc       = r.ax[a].pc + 10'h001;
								end
							end
							OP_PEND: begin
								if (!r.ax[a].busy) begin
									n.ax[a].st = ST_IDLE;
								end
							end
							OP_SEND: begin
								if (r.ax[a].sp == 4'h0) begin
									kill[a] = 1'b1;
								end else begin
									n.ax[a].sp = r.ax[a].sp - 4'h1;
									n.ax[a].pc = r.ax[a].stk[r.ax[a].sp[2:0] - 3'd1];
								end
							end
							default: kill[a] = 1'b1;
						endcase
					end
				end
				default: ;
			endcase
		end
		// Both axes leave the sync point in the same cycle; each then issues its next move in its own decode slot.
		if (r.ax[0].st == ST_SYNCW && r.ax[1].st == ST_SYNCW && r.ax[0].sync_c == r.ax[1].sync_c) begin
			n.ax[0].st = ST_FETCH;
			n.ax[1].st = ST_FETCH;
		end
		for (int i = 0; i < NAX; i++) begin
			stp[i] = r.ax[i].st != ST_IDLE && (r.abort[i] || !r.endrv[i] || !r.s2[PIN_OT+i] ||
				r.s2[PIN_EOT+i] || r.s2[PIN_SERR+i] || kill[i]);
			if (kill[i]) begin
				n.err[i] = 1'b1;
			end
		end
		if (r.ax[0].multi && r.ax[1].multi && (stp[0] || stp[1])) begin
			stp[1:0] = 2'b11;
		end
		for (int i = 0; i < NAX; i++) begin
			if (stp[i]) begin
				n.ax[i].st    = ST_IDLE;
				n.ax[i].busy  = 1'b0;
				n.ax[i].multi = 1'b0;
				n.ax[i].sp    = 4'h0;
			end
		end
		if (r.ax[0].st == ST_FETCH && !r.ax[0].busy && !r.ax[0].mv_start) begin
			n.gap = (r.gap == 18'h3FFFF) ? r.gap : r.gap + 18'h00001;
		end else begin
			n.gap = 18'h00000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r       <= '0;
			r.abort <= RST_ABORT;
			r.endrv <= RST_ENDRV;
			r.psel  <= RST_PSEL;
		end else begin
			r <= n;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_stop_abort: assert property (r.ax[0].st != ST_IDLE && r.abort[0] |=> r.ax[0].st == ST_IDLE)
		else $error("Axis 0 kept running after abort.");
	a_start_gate: assert property (r.ax[0].st == ST_IDLE ##1 r.ax[0].st == ST_ENTRY |-> $past(pre_ok[0]))
		else $error("Axis 0 started without prerequisites.");
	a_nest_bound: assert property (r.ax[0].sp <= NEST && r.ax[1].sp <= NEST)
		else $error("Subroutine nesting exceeded eight.");
	a_sync_pair: assert property (r.ax[0].st == ST_SYNCW ##1 r.ax[0].st == ST_FETCH |-> $past(r.ax[1].st) == ST_SYNCW
		&& r.ax[1].st == ST_FETCH)
		else $error("Axis 0 left sync alone.");
	a_one_move: assert property (r.ax[0].mv_start |-> r.ax[0].busy && !$past(r.ax[0].busy))
		else $error("Move issued over a running move.");
	a_label_out: assert property (r.ax[0].mv_start |-> r.ax[0].lbl == $past(r.ax[0].lblp))
		else $error("Block number not updated with move.");
	a_set_apply: assert property (r.ax[1].mv_start |-> r.ax[1].vel == $past(r.ax[1].velp)
		&& r.ax[1].acc == $past(r.ax[1].accp))
		else $error("Settings not applied to move.");
	a_multi_axes: assert property (!r.ax[2].multi && !r.ax[3].multi)
		else $error("Multi-axis program reached axis 3 or 4.");
	a_gap_bound: assert property (r.gap < GAP_LIMIT_CYC)
		else $error("Block transition exceeded two milliseconds.");

endmodule : mps_seq
`default_nettype wire

// [mps_seq_tb.sv]
// Self-checking bench for the motion program sequencer: APB tasks and directed program runs.
// Assumes the motion core model answers every move issued on axis 0.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module mps_seq_tb;
	import mps_pkg::*;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, r, ctl;
	logic [3:0]   mv_start, moving, mv_done, serr, eot;
	logic [7:0]   mv_kind;
	logic [127:0] mv_value;
	logic [63:0]  mv_vel, mv_acc;
	logic [15:0]  dly;
	logic [31:0]  prog [20];
	logic [1:0]   kq [$];
	logic [31:0]  vq [$];
	logic [15:0]  wq [$];
	int           fail_count, n_tests, cyc;

	// The gap limit is shortened so the spacing assertion fires within a short run.
	mps_seq #(.GAP_LIMIT_CYC(64)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .drive_ok(4'hF), .pos_valid(4'hF), .moving(moving), .ot_ok(4'hF),
		.in_limits(4'hF), .eot_hit(eot), .stop_err(serr), .mv_done(mv_done),
		.external_control_bit(ctl), .mv_start(mv_start), .mv_kind(mv_kind), .mv_value(mv_value),
		.mv_vel(mv_vel), .mv_acc(mv_acc));
	mps_core_model core (.pclk(pclk), .presetn(presetn), .mv_start(mv_start), .dly(dly),
		.moving(moving), .mv_done(mv_done));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc++;
		if (mv_start[0] === 1'b1) begin
			kq.push_back(mv_kind[1:0]);
			vq.push_back(mv_value[31:0]);
			wq.push_back(mv_vel[15:0]);
		end
		if (cyc == 20000) begin
			fail_count++;
			results();
		end
	end

	function automatic logic [31:0] st(input mps_op_t op, input logic f, input logic [4:0] ix, input logic [15:0] im);
		return {op, 2'b00, f, ix, 4'h0, im};
	endfunction : st

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle cycle, so a following call never drives psel twice in one time step.
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd

	// Waits for the expected moves, then for the active flags of axes 0 and 1 to drop.
	task automatic run(input logic [31:0] c, input int n);
		kq.delete();
		vq.delete();
		wq.delete();
		ctl <= c;
		wr(A_CTRL, 32'h0000_0301);
		while (kq.size() < n) @(posedge pclk);
		do rd(A_STAT); while (r[1:0] !== 2'b00);
	endtask : run

	task automatic results;
		$display("Counts: %0d comparisons, %0d mismatches", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		serr = 4'h0;
		eot = 4'h0;
		ctl = 32'h0000_0000;
		dly = 16'h0005;
		prog = '{st(OP_SET_VELOCITY, 1'b0, 5'h00, 16'h0010),
			st(OP_LABEL, 1'b0, 5'h00, 16'h0005),
			st(OP_POSITIONING_MOVE, 1'b0, 5'h00, 16'h0100),
			st(OP_JUMP, 1'b1, 5'h03, 16'h0006),
			st(OP_CONTINUOUS_MOVE, 1'b0, 5'h00, 16'h0200),
			st(OP_PEND, 1'b0, 5'h00, 16'h0000),
			st(OP_LABEL, 1'b0, 5'h00, 16'h0007),
			st(OP_LOAD, 1'b0, 5'h02, 16'h0055),
			st(OP_WAIT, 1'b1, 5'h02, 16'h0000),
			st(OP_PEND, 1'b0, 5'h00, 16'h0000),
			st(OP_NOP, 1'b0, 5'h00, 16'h0000),
			st(OP_CALL, 1'b0, 5'h00, 16'h0001),
			st(OP_PEND, 1'b0, 5'h00, 16'h0000),
			st(OP_SET_ACCELERATION, 1'b0, 5'h00, 16'h0020),
			st(OP_DWELL, 1'b1, 5'h03, 16'h0000),
			st(OP_SEND, 1'b0, 5'h00, 16'h0000),
			st(OP_SYNC, 1'b0, 5'h00, 16'h0000),
			st(OP_POSITIONING_MOVE, 1'b0, 5'h00, 16'h0011),
			st(OP_POSITIONING_MOVE, 1'b0, 5'h00, 16'h0022) | 32'h0400_0000,
			st(OP_PEND, 1'b0, 5'h00, 16'h0000)};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(A_CTRL);
		`CHK(r, {20'h00000, RST_ENDRV, RST_ABORT, 4'h0})
		rd(A_STAT);
		`CHK(r, 32'h0000_0000)
		rd(12'h020);
		`CHK(e, 1'b1)
		$display("test reset done");
		wr(A_LDADR, 32'h0000_0000);
		foreach (prog[i]) wr(A_LDDAT, prog[i]);
		wr(A_LDADR, {21'h000000, TBL_PROG});
		wr(A_LDDAT, 32'h8000_0000);
		wr(A_LDDAT, 32'hC000_0010);
		wr(A_LDDAT, 32'h8000_000A);
		wr(A_LDADR, {21'h000000, TBL_SUB});
		wr(A_LDDAT, 32'h8000_000D);
		wr(A_CTRL, 32'h0000_0100);
		wr(A_PSEL, 32'h0000_0002);
		wr(A_CTRL, 32'h0000_0101);
		wr(A_CTRL, 32'h0000_0102);
		rd(A_STAT);
		`CHK(r, 32'h0000_0130)
		wr(A_STAT, 32'h0000_0130);
		rd(A_STAT);
		`CHK(r, 32'h0000_0000)
		wr(A_PSEL, 32'h0000_0001);
		$display("test refuse done");
		run(32'h0000_0000, 2);
		`CHK(kq[0], 2'h0)
		`CHK(vq[0], 32'h0000_0100)
		`CHK(kq[1], 2'h1)
		`CHK(vq[1], 32'h0000_0200)
		`CHK(wq[1], 16'h0010)
		rd(A_BLK01);
		`CHK(r[15:0], 16'h0005)
		$display("test run1 done");
		run(32'h0000_0008, 2);
		`CHK(kq[1], 2'h3)
		`CHK(vq[1], 32'h0000_0055)
		rd(A_BLK01);
		`CHK(r[15:0], 16'h0007)
		rd(A_PAR0 + 12'h008);
		`CHK(r, 32'h0000_0055)
		$display("test run2 done");
		wr(A_PSEL, 32'h0000_0002);
		run(32'h0000_0000, 1);
		`CHK(vq[0], 32'h0000_0011)
		`CHK(mv_value[63:32], 32'h0000_0022)
		rd(A_STAT);
		`CHK(r, 32'h0000_0000)
		$display("test multi done");
		wr(A_PSEL, 32'h0000_0003);
		wr(A_PAR0 + 12'h00C, 32'h0000_0033);
		run(32'h0000_0000, 1);
		`CHK(kq[0], 2'h2)
		`CHK(vq[0], 32'h0000_0033)
		`CHK(mv_acc[15:0], 16'h0020)
		rd(A_STAT);
		`CHK(r[11:8], 4'h0)
		$display("test call done");
		dly <= 16'h012C;
		ctl <= 32'h0000_0000;
		kq.delete();
		wr(A_CTRL, 32'h0000_0101);
		while (kq.size() < 1) @(posedge pclk);
		serr <= 4'h1;
		repeat (8) @(posedge pclk);
		rd(A_STAT);
		`CHK(r[0], 1'b0)
		serr <= 4'h0;
		repeat (400) @(posedge pclk);
		`CHK(kq.size(), 1)
		kq.delete();
		wr(A_CTRL, 32'h0000_0101);
		while (kq.size() < 1) @(posedge pclk);
		eot <= 4'h1;
		repeat (8) @(posedge pclk);
		rd(A_STAT);
		`CHK(r[0], 1'b0)
		eot <= 4'h0;
		$display("test stop done");
		results();
	end
endmodule : mps_seq_tb
`default_nettype wire
